// File: spi_pkg.sv
// Constants and types shared by the serial port block and its helpers.
// Assumes a 10 MHz system clock and a byte-wide plain register port.
`default_nettype none
package spi_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h11;
  localparam logic [7:0] OFS_DATA = 8'h12;
  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  localparam logic [7:0] STAT_RST = 8'h08;
  // ****************************************
  // Status register field positions
  // ****************************************
  localparam int ST_RXF = 7;
  localparam int ST_ERROR_IRQ_ENABLE = 6;
  localparam int ST_OVF = 5;
  localparam int ST_MF = 4;
  localparam int ST_TXE = 3;
  localparam int ST_MFEN = 2;
  localparam int ST_RATE_HI = 1;
  localparam int ST_RATE_LO = 0;
  // ****************************************
  // Pin indices
  // ****************************************
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SS = 3;
  // ****************************************
  // Transfer timing
  // ****************************************
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [7:0] DIV_0 = 8'h02;
  localparam logic [7:0] DIV_1 = 8'h08;
  localparam logic [7:0] DIV_2 = 8'h20;
  localparam logic [7:0] DIV_3 = 8'h80;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic rx_irq_enable;
    logic rsv;
    logic master_select;
    logic cpol;
    logic cpha;
    logic wired_or_mode;
    logic module_enable;
    logic tx_irq_enable;
  } ctrl_t;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pins_t;
endpackage
`default_nettype wire

// File: spi_sync2.sv
// Two-flop synchroniser for pin levels.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module spi_sync2 #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output var logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule // spi_sync2
`default_nettype wire

// File: spi_tick_gen.sv
// Half-period tick source for the master serial clock.
// Assumes run is held for the whole transfer.
`timescale 1ns/1ns
`default_nettype none
module spi_tick_gen (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [1:0] rate,
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] half;

  function automatic logic [7:0] half_len(input logic [1:0] r);
    case (r)
      2'h0: half_len = spi_pkg::DIV_0;
      2'h1: half_len = spi_pkg::DIV_1;
      2'h2: half_len = spi_pkg::DIV_2;
      default: half_len = spi_pkg::DIV_3;
    endcase
  endfunction

  assign half = half_len(rate);
  assign tick = run && (cnt_r == half - 8'h01);

  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    if (!run || tick) begin
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // spi_tick_gen
`default_nettype wire

// File: spi_port_ctrl.sv
// Serial peripheral port: pin ownership, control and status registers, byte shifter.
// Assumes a plain register port on sys_clk and asynchronous pins.
// Function
// - Wired-or mode drops pullups; clock and data pins become open drain.
// - Data-out to master driven only as enabled slave with select low.
// - Select high as slave: data-out floats, clock edges ignored, transfer aborted.
// - Enabled module owns direction of data and clock pins over port.
// - Master drives clock, slave reads it; a byte takes eight clocks.
// - Slave always takes select as input; fault enable only gates faults.
// - Master without fault enable leaves select to port; with it, input.
// - Select level always readable by the port data path.
// - Receive interrupt enable gates receive-full onto interrupt; reset clears.
// - Master-select bit: 1 master, 0 slave; reset sets it.
// - Clock polarity sets clock idle level; reset clears it.
// - Clock phase sets edge to data timing; reset sets it.
// - Enable bit turns module on; clearing it partially resets.
// - Transmit enable gates tx-empty flag; flag sets on shifter load.
// - Receive-full sets on byte done; cleared by status then data read.
// - Error enable gates fault and overflow flags onto interrupt.
// - Disabled: abort, clear shifter and counter, set tx-empty, port owns pins.
// - Fault enabled: master faults on select low, slave on select rise mid-byte.
// - Byte done while receive full: set overflow, keep old byte.
`timescale 1ns/1ns
`default_nettype none
module spi_port_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output var logic [7:0] rdata,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_dir,
  output var spi_pkg::pins_t pin_drive,
  output logic [2:0] pullup_en,
  output logic [3:0] pin_level,
  output logic rx_irq,
  output logic tx_irq
);
  // ****************************************
  // State
  // ****************************************
  spi_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic rxf_r, rxf_nxt, ovf_r, ovf_nxt, mf_r, mf_nxt, txe_r, txe_nxt;
  logic error_irq_enable_r, error_irq_enable_nxt, mfen_r, mfen_nxt;
  logic [1:0] rate_r, rate_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, sh_r, sh_nxt, rdata_nxt;
  logic rxbit_r, rxbit_nxt, busy_r, busy_nxt, sck_r, sck_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic arm_rf_r, arm_rf_nxt, arm_ov_r, arm_ov_nxt, arm_mf_r, arm_mf_nxt;
  logic ss_q_r, sck_q_r;
  logic [3:0] pin_s;
  logic tick, ss_s, sck_s, din, slave, sck_edge, ev, done, m_fault, s_fault;
  logic [7:0] byte_in;
  logic [7:0] stat_val;
  logic [1:0] drv [3];
  logic [3:0] own;

  function automatic logic [1:0] pin_drv(input logic val, input logic en, input logic od);
    pin_drv = od ? {1'b0, en && !val} : {val, en};
  endfunction

  // ****************************************
  // Pin sampling and master clock
  // ****************************************
  spi_sync2 #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .din(pin_in),
    .dout(pin_s)
  );

  spi_tick_gen u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(busy_r && ctrl_r.master_select && ctrl_r.module_enable),
    .rate(rate_r),
    .tick(tick)
  );

  assign ss_s = pin_s[spi_pkg::PIN_SS];
  assign sck_s = pin_s[spi_pkg::PIN_SCK];
  assign pin_level = pin_s;
  assign slave = ctrl_r.module_enable && !ctrl_r.master_select;
  assign din = ctrl_r.master_select ? pin_s[spi_pkg::PIN_MISO] : pin_s[spi_pkg::PIN_MOSI];
  assign sck_edge = sck_s != sck_q_r;
  // Slave counts edges only while selected; phase 1 starts on first edge
  assign ev = ctrl_r.master_select ? (busy_r && tick)
            : (!ss_s && sck_edge && (busy_r || ctrl_r.cpha));
  assign done = ctrl_r.module_enable && ev && idx_r == spi_pkg::LAST_EDGE;
  assign byte_in = {sh_r[6:0], ctrl_r.cpha ? din : rxbit_r};
  assign m_fault = ctrl_r.module_enable && ctrl_r.master_select && mfen_r && !ss_s;
  assign s_fault = slave && mfen_r && ss_s && busy_r;
  assign stat_val = {rxf_r, error_irq_enable_r, ovf_r, mf_r, txe_r, mfen_r, rate_r};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    rxf_nxt = rxf_r;
    ovf_nxt = ovf_r;
    mf_nxt = mf_r;
    txe_nxt = txe_r;
    error_irq_enable_nxt = error_irq_enable_r;
    mfen_nxt = mfen_r;
    rate_nxt = rate_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    sh_nxt = sh_r;
    rxbit_nxt = rxbit_r;
    busy_nxt = busy_r;
    sck_nxt = sck_r;
    idx_nxt = idx_r;
    arm_rf_nxt = arm_rf_r;
    arm_ov_nxt = arm_ov_r;
    arm_mf_nxt = arm_mf_r;
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        spi_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
        spi_pkg::OFS_STAT: begin
          rdata_nxt = stat_val;
          arm_rf_nxt = rxf_r;
          arm_ov_nxt = ovf_r;
          arm_mf_nxt = mf_r;
        end
        spi_pkg::OFS_DATA: begin
          rdata_nxt = rx_r;
          if (arm_rf_r) rxf_nxt = 1'b0;
          if (arm_ov_r) ovf_nxt = 1'b0;
          arm_rf_nxt = 1'b0;
          arm_ov_nxt = 1'b0;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (wr) begin
      case (addr)
        spi_pkg::OFS_CTRL: begin
          ctrl_nxt = spi_pkg::ctrl_t'(wdata & spi_pkg::CTRL_WMASK);
          if (arm_mf_r && !m_fault && !s_fault) mf_nxt = 1'b0;
          arm_mf_nxt = 1'b0;
        end
        spi_pkg::OFS_STAT: begin
          error_irq_enable_nxt = wdata[spi_pkg::ST_ERROR_IRQ_ENABLE];
          mfen_nxt = wdata[spi_pkg::ST_MFEN];
          rate_nxt = wdata[spi_pkg::ST_RATE_HI:spi_pkg::ST_RATE_LO];
        end
        spi_pkg::OFS_DATA: tx_nxt = wdata;
        default: tx_nxt = tx_r;
      endcase
    end
    if (ctrl_r.module_enable) begin
      if (!busy_r && !txe_r) begin
        sh_nxt = tx_r;
        txe_nxt = 1'b1;
        busy_nxt = ctrl_r.master_select;
      end
      if (slave && ss_s) begin
        busy_nxt = 1'b0;
        idx_nxt = 4'h0;
      end else if (slave && ss_q_r && !ss_s && !ctrl_r.cpha) begin
        busy_nxt = 1'b1;
      end
      if (ev) begin
        idx_nxt = idx_r + 4'h1;
        busy_nxt = 1'b1;
        if (ctrl_r.master_select) sck_nxt = !sck_r;
        if (idx_r == spi_pkg::LAST_EDGE) begin
          busy_nxt = 1'b0;
          idx_nxt = 4'h0;
          sh_nxt = byte_in;
          if (rxf_r) begin
            ovf_nxt = 1'b1;
          end else begin
            rx_nxt = byte_in;
            rxf_nxt = 1'b1;
          end
        end else if (idx_r[0] == ctrl_r.cpha) begin
          rxbit_nxt = din;
        end else if (idx_r != 4'h0) begin
          sh_nxt = {sh_r[6:0], rxbit_r};
        end
      end
      if (!busy_r) sck_nxt = ctrl_r.cpol;
    end else begin
      busy_nxt = 1'b0;
      idx_nxt = 4'h0;
      sh_nxt = 8'h00;
      sck_nxt = ctrl_r.cpol;
    end
    if (wr && addr == spi_pkg::OFS_DATA) txe_nxt = 1'b0;
    if (!ctrl_r.module_enable) txe_nxt = 1'b1;
    if (m_fault) begin
      mf_nxt = 1'b1;
      ctrl_nxt.module_enable = 1'b0;
    end
    if (s_fault) mf_nxt = 1'b1;
    if (done) begin
      if (rxf_r) ovf_nxt = 1'b1;
      else rxf_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= spi_pkg::ctrl_t'(spi_pkg::CTRL_RST);
      rxf_r <= spi_pkg::STAT_RST[spi_pkg::ST_RXF];
      error_irq_enable_r <= spi_pkg::STAT_RST[spi_pkg::ST_ERROR_IRQ_ENABLE];
      ovf_r <= spi_pkg::STAT_RST[spi_pkg::ST_OVF];
      mf_r <= spi_pkg::STAT_RST[spi_pkg::ST_MF];
      txe_r <= spi_pkg::STAT_RST[spi_pkg::ST_TXE];
      mfen_r <= spi_pkg::STAT_RST[spi_pkg::ST_MFEN];
      rate_r <= spi_pkg::STAT_RST[spi_pkg::ST_RATE_HI:spi_pkg::ST_RATE_LO];
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      sh_r <= 8'h00;
      rxbit_r <= 1'b0;
      busy_r <= 1'b0;
      sck_r <= 1'b0;
      idx_r <= 4'h0;
      arm_rf_r <= 1'b0;
      arm_ov_r <= 1'b0;
      arm_mf_r <= 1'b0;
      rdata <= 8'h00;
      ss_q_r <= 1'b1;
      sck_q_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rxf_r <= rxf_nxt;
      error_irq_enable_r <= error_irq_enable_nxt;
      ovf_r <= ovf_nxt;
      mf_r <= mf_nxt;
      txe_r <= txe_nxt;
      mfen_r <= mfen_nxt;
      rate_r <= rate_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      sh_r <= sh_nxt;
      rxbit_r <= rxbit_nxt;
      busy_r <= busy_nxt;
      sck_r <= sck_nxt;
      idx_r <= idx_nxt;
      arm_rf_r <= arm_rf_nxt;
      arm_ov_r <= arm_ov_nxt;
      arm_mf_r <= arm_mf_nxt;
      rdata <= rdata_nxt;
      ss_q_r <= ss_s;
      sck_q_r <= sck_s;
    end
  end

  // ****************************************
  // Pin ownership and drivers
  // ****************************************
  assign drv[spi_pkg::PIN_MISO] = pin_drv(sh_r[7], slave && !ss_s, ctrl_r.wired_or_mode);
  assign drv[spi_pkg::PIN_MOSI] = pin_drv(sh_r[7], ctrl_r.master_select, ctrl_r.wired_or_mode);
  assign drv[spi_pkg::PIN_SCK] = pin_drv(sck_r, ctrl_r.master_select, ctrl_r.wired_or_mode);
  assign own[2:0] = {3{ctrl_r.module_enable}};
  assign own[spi_pkg::PIN_SS] = ctrl_r.module_enable && (!ctrl_r.master_select || mfen_r);
  assign pullup_en = {3{!ctrl_r.wired_or_mode}};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_pin
      assign pin_drive.out[i] = own[i] ? drv[i][1] : gpio_out[i];
      assign pin_drive.oe[i] = own[i] ? drv[i][0] : gpio_dir[i];
    end
  endgenerate
  assign pin_drive.out[spi_pkg::PIN_SS] = own[spi_pkg::PIN_SS] ? 1'b0 : gpio_out[spi_pkg::PIN_SS];
  assign pin_drive.oe[spi_pkg::PIN_SS] = own[spi_pkg::PIN_SS] ? 1'b0 : gpio_dir[spi_pkg::PIN_SS];

  assign rx_irq = (rxf_r && ctrl_r.rx_irq_enable) || (error_irq_enable_r && (ovf_r || mf_r));
  assign tx_irq = txe_r && ctrl_r.tx_irq_enable && ctrl_r.module_enable;

  // ****************************************
  // Assertions
  // ****************************************
  logic [3:0] tog_r;
  always_ff @(posedge sys_clk) begin
    if (srst || !busy_r) tog_r <= 4'h0;
    else if (sck_r != $past(sck_r)) tog_r <= tog_r + 4'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_miso_master_off: assert property (ctrl_r.module_enable && ctrl_r.master_select
    |-> !pin_drive.oe[spi_pkg::PIN_MISO]) else $error("master drives data-out");
  a_ss_high_float: assert property (slave && ss_s |-> !pin_drive.oe[spi_pkg::PIN_MISO])
    else $error("unselected slave drives");
  a_ss_high_abort: assert property (slave && ss_s |=> !busy_r && idx_r == 4'h0)
    else $error("unselected slave kept counting");
  a_disable_clears: assert property (!ctrl_r.module_enable |=> txe_r && !busy_r && sh_r == 8'h00)
    else $error("disable did not reset shifter");
  a_overflow_keeps: assert property (done && rxf_r |=> ovf_r && rx_r == $past(rx_r))
    else $error("overflow lost old byte");
  a_rxfull_sets: assert property (done && !rxf_r |=> rxf_r && rx_r == $past(byte_in))
    else $error("receive full not set");
  a_master_fault: assert property (m_fault |=> mf_r && !ctrl_r.module_enable)
    else $error("master fault missed");
  a_eight_clocks: assert property (done && ctrl_r.master_select |-> tog_r == 4'hf)
    else $error("byte not sixteen clock edges");
  a_sck_idle: assert property (ctrl_r.module_enable && ctrl_r.master_select && !busy_r
    ##1 !busy_r |-> sck_r == $past(ctrl_r.cpol)) else $error("clock not idle");
  a_wired_or: assert property (ctrl_r.wired_or_mode && ctrl_r.module_enable
    && pin_drive.oe[spi_pkg::PIN_MOSI] |-> !pin_drive.out[spi_pkg::PIN_MOSI])
    else $error("open drain drove high");
  a_err_irq: assert property (!error_irq_enable_r && !(rxf_r && ctrl_r.rx_irq_enable) |-> !rx_irq)
    else $error("error irq not gated");

  c_master_byte: cover property (done && ctrl_r.master_select);
  c_slave_byte: cover property (done && !ctrl_r.master_select);
  c_overflow: cover property (done && rxf_r);
  c_fault: cover property (m_fault || s_fault);
endmodule // spi_port_ctrl
`default_nettype wire

// File: spi_far_model.sv
// Far-end model: serial slave while the device masters, serial master while it is slave.
// Assumes the bench resolves each pin from every driver and feeds the level back.
`timescale 1ns/1ns
`default_nettype none
module spi_far_model (
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  output logic miso_out,
  output logic miso_oe,
  output var logic m_sck,
  output var logic m_mosi,
  output var logic m_ss_n,
  output var logic ss_oe
);
  // ****************************************
  // Slave side
  // ****************************************
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  logic s_sel = 1'b0;
  int edges = 0;
  logic mosi_q = 1'b1;
  assign miso_out = tx_sh[7];
  assign miso_oe = s_sel;
  // Data-out level from just before the clock edge; the device may move both at once
  always @(mosi) mosi_q <= #1 mosi;
  // Sample on one edge and shift on the other, same phase as the device
  always @(sck) begin
    if (s_sel) begin
      if ((sck != cpol) != cpha) begin
        rx_sh = {rx_sh[6:0], mosi_q};
      end else if (edges > 0) begin
        tx_sh = {tx_sh[6:0], 1'b0};
      end
      edges = edges + 1;
    end
  end
  task automatic slave_load(input logic [7:0] b);
    tx_sh = b;
    edges = 0;
    s_sel = 1'b1;
  endtask
  task automatic slave_done;
    s_sel = 1'b0;
  endtask
  // ****************************************
  // Master side
  // ****************************************
  initial begin
    m_sck = 1'b0;
    m_mosi = 1'b1;
    m_ss_n = 1'b1;
    ss_oe = 1'b0;
  end
  // Select toggles around bytes; clock idles at polarity between them
  task automatic sel(input logic v);
    #137;
    m_sck = cpol;
    m_ss_n = v;
    ss_oe = 1'b1;
  endtask
  // Data changes on the leading edge, sampled on the trailing one
  task automatic shift(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      m_mosi = b[7-i];
      m_sck = !cpol;
      #400;
      rx_sh = {rx_sh[6:0], miso};
      m_sck = cpol;
      #400;
    end
  endtask
endmodule // spi_far_model
`default_nettype wire

// File: spi_pins_and_control_bits_test.sv
// Bench for the serial port block: registers, master and slave bytes, faults.
// Assumes the package, design files and far-end model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module spi_pins_and_control_bits_test;
  localparam logic [7:0] CTL = spi_pkg::OFS_CTRL;
  localparam logic [7:0] STA = spi_pkg::OFS_STAT;
  localparam logic [7:0] DAT = spi_pkg::OFS_DATA;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] gpio_out = 4'ha;
  logic [3:0] gpio_dir = 4'hf;
  logic cpol_r = 1'b0;
  logic cpha_r = 1'b1;
  logic [7:0] rdata;
  spi_pkg::pins_t pd;
  logic [2:0] pullup_en;
  logic [3:0] pin_level;
  logic rx_irq, tx_irq, p_miso, p_miso_oe, p_sck, p_mosi, p_ss_n, p_ss_oe;
  wire logic miso_w, mosi_w, sck_w, ss_w, p_drv;
  int fail_count = 0;
  int checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  // ****************************************
  // Pin resolution and instances
  // ****************************************
  assign p_drv = p_ss_oe && !p_ss_n;
  assign miso_w = pd.oe[0] ? pd.out[0] : (p_miso_oe ? p_miso : 1'b1);
  assign mosi_w = pd.oe[1] ? pd.out[1] : (p_drv ? p_mosi : 1'b1);
  assign sck_w = pd.oe[2] ? pd.out[2] : (p_drv ? p_sck : cpol_r);
  assign ss_w = p_ss_oe ? p_ss_n : (pd.oe[3] ? pd.out[3] : 1'b1);
  spi_port_ctrl uut (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in({ss_w, sck_w, mosi_w, miso_w}), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .pin_drive(pd), .pullup_en(pullup_en), .pin_level(pin_level),
    .rx_irq(rx_irq), .tx_irq(tx_irq));
  spi_far_model p (.cpol(cpol_r), .cpha(cpha_r), .sck(sck_w), .mosi(mosi_w), .miso(miso_w),
    .miso_out(p_miso), .miso_oe(p_miso_oe), .m_sck(p_sck), .m_mosi(p_mosi),
    .m_ss_n(p_ss_n), .ss_oe(p_ss_oe));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, e, "read");
  endtask
  task automatic rx_chk(input logic [7:0] e);
    logic [7:0] d;
    rd_reg(STA, d);
    check(8'(d[7]), 8'h01, "rx full");
    rd_chk(DAT, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic xfer_wait;
    int i;
    for (i = 0; i < 3000 && p.edges < 16; i++) @(posedge sys_clk);
    if (i >= 3000) begin
      fail_count++;
      $display("[FAIL] %0t transfer hung", $time);
      results();
    end else begin
      repeat (6) @(posedge sys_clk);
      p.slave_done();
      #1;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk(CTL, spi_pkg::CTRL_RST);
    rd_chk(STA, spi_pkg::STAT_RST);
    rd_chk(8'h13, 8'h00);
    check(8'(pd.oe), 8'(gpio_dir), "oe at reset");
    check(8'(pullup_en), 8'h07, "pullups");
    gpio_dir <= 4'h5;
    wr_reg(CTL, 8'hff);
    wr_reg(8'h13, 8'h00);
    rd_chk(CTL, spi_pkg::CTRL_WMASK);
    check(8'(pullup_en), 8'h00, "wired-or");
    check(8'({pd.oe[0], tx_irq}), 8'h01, "miso in, tx irq");
    wr_reg(CTL, 8'h00);
    check(8'({pd.oe, pullup_en}), 8'h2f, "port owns");
    gpio_out <= 4'h5;
    @(posedge sys_clk);
    #1;
    check(8'(pd.out), 8'h05, "port data out");
    gpio_out <= 4'ha;
    gpio_dir <= 4'hf;
    $display("register test done");
  endtask
  task automatic t_master;
    int i;
    int hp;
    wr_reg(STA, 8'h41);
    wr_reg(CTL, 8'hab);
    check(8'(pd.oe), 8'h0e, "master oe");
    check(8'(pd.out[3:2]), 8'h02, "ss port, sck idle");
    p.slave_load(8'h3c);
    wr_reg(DAT, 8'ha5);
    check(8'(tx_irq), 8'h00, "tx full");
    for (i = 0; i < 500 && sck_w == cpol_r; i++) @(negedge sys_clk);
    for (hp = 0; hp < 500 && sck_w != cpol_r; hp++) @(negedge sys_clk);
    check(8'(hp), 8'(spi_pkg::DIV_1), "half period");
    xfer_wait();
    check(8'(p.edges), 8'h10, "edges");
    check(p.rx_sh, 8'ha5, "mosi byte");
    check(8'({rx_irq, tx_irq}), 8'h03, "irqs");
    rd_chk(STA, 8'hc9);
    cpol_r <= 1'b1;
    cpha_r <= 1'b0;
    wr_reg(CTL, 8'hb3);
    @(posedge sys_clk);
    #1;
    check(8'(pd.out[2]), 8'h01, "sck idle high");
    p.slave_load(8'h99);
    wr_reg(DAT, 8'h5e);
    xfer_wait();
    check(p.rx_sh, 8'h5e, "phase 0 byte");
    rd_chk(STA, 8'he9);
    check(8'(rx_irq), 8'h01, "error irq");
    rd_chk(DAT, 8'h3c);
    rd_chk(STA, 8'h49);
    $display("master test done");
  endtask
  task automatic t_fault;
    cpol_r <= 1'b0;
    wr_reg(STA, 8'h45);
    wr_reg(CTL, 8'h22);
    check(8'(pd.oe), 8'h06, "select input only");
    p.sel(1'b0);
    repeat (6) @(posedge sys_clk);
    #1;
    check(8'(pin_level[3]), 8'h00, "select level");
    rd_chk(STA, 8'h5d);
    rd_chk(CTL, 8'h20);
    check(8'(pd.oe), 8'(gpio_dir), "port after fault");
    check(8'(rx_irq), 8'h01, "fault irq");
    wr_reg(STA, 8'h05);
    check(8'(rx_irq), 8'h00, "error irq off");
    p.sel(1'b1);
    $display("fault test done");
  endtask
  task automatic t_slave;
    logic [7:0] d;
    cpha_r <= 1'b1;
    wr_reg(STA, 8'h04);
    wr_reg(CTL, 8'h8a);
    wr_reg(DAT, 8'hc3);
    check(8'(pd.oe), 8'h00, "slave unselected");
    p.sel(1'b0);
    repeat (6) @(posedge sys_clk);
    #1;
    check(8'(pd.oe), 8'h01, "slave drives miso");
    p.shift(8, 8'h5a);
    p.sel(1'b1);
    repeat (8) @(posedge sys_clk);
    check(p.rx_sh, 8'hc3, "miso byte");
    rx_chk(8'h5a);
    p.sel(1'b0);
    p.shift(4, 8'hf0);
    p.sel(1'b1);
    repeat (6) @(posedge sys_clk);
    #1;
    check(8'(pd.oe[0]), 8'h00, "miso floats");
    rd_reg(STA, d);
    check(8'(d[4]), 8'h01, "slave fault");
    p.sel(1'b0);
    p.shift(8, 8'h81);
    p.sel(1'b1);
    repeat (8) @(posedge sys_clk);
    rx_chk(8'h81);
    $display("slave test done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_master();
    t_fault();
    t_slave();
    results();
  end
endmodule // spi_pins_and_control_bits_test
`default_nettype wire
